// file: hdl/flash_self_program_unlock_erase.sv
// Flash self-programming sequencer with unlock guard, register slave
// on Avalon-MM and the core handshake (forced no-ops and stall).
// Assumes the core pulses instr_slot once per instruction slot on clk.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

// Notes on behaviour
// - Unlock is 55h, AAh, start bit, two no-ops.
// - Two slots after start become no-ops.
// - Erase or program stalls core about 2 ms.
// - Latch load: two no-ops, then no stall.
// - Erase takes the whole row holding the address.
// - Stall holds execution only; clocks keep running.
// - Execution resumes at third slot after start.
// - Read: first slot fetches, second loads the word.
// - Start bits only set by software, hardware clears.
// - Latch-load-only bit chooses latch load or program.
// - Latches return to 3FFFh after write or erase.
module flash_self_program_unlock_erase
  import flash_seq_pkg::*;
#(
  parameter int unsigned OP_CYCLES = `FLASH_OP_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic instr_slot,
  output logic force_nop,
  output logic stall_core
);

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  logic read_start, next_read_start;          // Read in progress.
  logic write_start, next_write_start;        // Write or erase in progress.
  logic write_enable_bit, next_write_enable_bit;
  logic row_erase_bit, next_row_erase_bit;
  logic latch_load_only_bit, next_latch_load_only_bit;
  logic config_space_select_bit, next_config_space_select_bit;
  logic [7:0] flash_addr_low, next_flash_addr_low;
  logic [6:0] flash_addr_high, next_flash_addr_high;
  logic [7:0] flash_data_low, next_flash_data_low;
  logic [5:0] flash_data_high, next_flash_data_high;
  logic op_erase, next_op_erase;              // Started op is an erase.
  logic op_load, next_op_load;                // Started op only loads.
  logic [31:0] timer, next_timer;             // Stall cycles remaining.
  row_t latch, next_latch;                    // Write latches.
  seq_state_t seq, next_seq;
  unlock_state_t ulk, next_ulk;
  logic read_ack, next_read_ack;              // Read answer cycle.
  logic [31:0] next_readdata;
  logic wr_acc;                               // Write taken this cycle.
  logic [3:0] latch_idx;                      // Latch picked by address.
  word_t data_word;                           // Data pair as one word.

  flash_port_if fp ();

  flash_mem u_mem
  (
    .clk(clk),
    .rst(rst),
    .port(fp.mem)
  );

  // Register index from a byte address; lower two bits are ignored.
  function automatic logic [2:0] reg_index(input logic [4:0] a);
    reg_index = a[4:2];
  endfunction : reg_index

  // -------------------------------------------------------------
  // Core handshake and bus strobes
  // -------------------------------------------------------------
  // The stall freezes only the core; this block and its clock run on,
  // and bus accesses simply wait until the operation ends.
  assign stall_core = (seq == SEQ_STALL);
  assign force_nop = (seq == SEQ_NOP1) || (seq == SEQ_NOP2)
    || (seq == SEQ_RD2);
  assign avs_waitrequest = stall_core || (avs_read && !read_ack);
  assign wr_acc = avs_write && !avs_waitrequest;
  assign latch_idx = flash_addr_low[3:0];
  assign data_word = {flash_data_high, flash_data_low};

  // -------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------
  // Bus writes come first; sequencer completion then overrides the
  // start bits and data pair, since the core cannot write meanwhile.
  always_comb
  begin
    next_read_start = read_start;
    next_write_start = write_start;
    next_write_enable_bit = write_enable_bit;
    next_row_erase_bit = row_erase_bit;
    next_latch_load_only_bit = latch_load_only_bit;
    next_config_space_select_bit = config_space_select_bit;
    next_flash_addr_low = flash_addr_low;
    next_flash_addr_high = flash_addr_high;
    next_flash_data_low = flash_data_low;
    next_flash_data_high = flash_data_high;
    next_op_erase = op_erase;
    next_op_load = op_load;
    next_timer = timer;
    next_latch = latch;
    next_seq = seq;
    next_ulk = ulk;
    fp.cmd = CMD_NONE;
    fp.addr = {flash_addr_high, flash_addr_low};
    fp.row_data = latch;
    fp.row_data[latch_idx] = data_word; // The last word rides along.

    if (wr_acc)
    begin
      // Any write other than a correct unlock step disarms the guard.
      next_ulk = ULK_IDLE;
      case (reg_index(avs_address))
        `IDX_CONTROL:
        begin
          next_write_enable_bit = avs_writedata[`BIT_WRITE_ENABLE];
          next_row_erase_bit = avs_writedata[`BIT_ROW_ERASE];
          next_latch_load_only_bit = avs_writedata[`BIT_LATCH_LOAD_ONLY];
          next_config_space_select_bit = avs_writedata[`BIT_CONFIG_SPACE];
          // Start bits are set-only; writing zero leaves them alone.
          if (avs_writedata[`BIT_READ_START] && seq == SEQ_IDLE)
          begin
            next_read_start = 1'b1;
            next_seq = SEQ_RD1;
          end
          else if (avs_writedata[`BIT_WRITE_START] && seq == SEQ_IDLE
            && ulk == ULK_ARMED && avs_writedata[`BIT_WRITE_ENABLE])
          begin
            next_write_start = 1'b1;
            next_seq = SEQ_NOP1;
            next_op_erase = avs_writedata[`BIT_ROW_ERASE];
            next_op_load = !avs_writedata[`BIT_ROW_ERASE]
              && avs_writedata[`BIT_LATCH_LOAD_ONLY];
          end
        end
        `IDX_UNLOCK:
        begin
          // Two steps in order; anything else restarts the pattern.
          if (ulk == ULK_IDLE && avs_writedata[7:0] == `UNLOCK_FIRST)
            next_ulk = ULK_GOT_FIRST;
          else if (ulk == ULK_GOT_FIRST
            && avs_writedata[7:0] == `UNLOCK_SECOND)
            next_ulk = ULK_ARMED;
          else
            next_ulk = ULK_IDLE;
        end
        `IDX_ADDR_LOW:
          next_flash_addr_low = avs_writedata[7:0];
        `IDX_ADDR_HIGH:
          next_flash_addr_high = avs_writedata[6:0];
        `IDX_DATA_LOW:
          next_flash_data_low = avs_writedata[7:0];
        `IDX_DATA_HIGH:
          next_flash_data_high = avs_writedata[5:0];
        default:
          next_ulk = ULK_IDLE;
      endcase
    end

    case (seq)
      SEQ_IDLE:
        next_seq = next_seq;
      SEQ_NOP1:
        if (instr_slot)
          next_seq = SEQ_NOP2;
      SEQ_NOP2:
        if (instr_slot)
        begin
          if (op_load)
          begin
            // Latch load ends here, with no stall at all.
            next_latch[latch_idx] = data_word;
            next_write_start = 1'b0;
            next_seq = SEQ_IDLE;
          end
          else
          begin
            next_timer = OP_CYCLES - 32'd1;
            next_seq = SEQ_STALL;
          end
        end
      SEQ_STALL:
        if (timer == 32'd0)
        begin
          // Config space is outside this array; the op only times out.
          if (!config_space_select_bit)
            fp.cmd = op_erase ? CMD_ERASE : CMD_PROGRAM;
          for (int i = 0; i < 16; i++)
            next_latch[i] = `BLANK_WORD;
          next_write_start = 1'b0;
          next_seq = SEQ_IDLE;
        end
        else
          next_timer = timer - 32'd1;
      SEQ_RD1:
        if (instr_slot)
        begin
          fp.cmd = CMD_READ;
          next_seq = SEQ_RD2;
        end
      SEQ_RD2:
        if (instr_slot)
        begin
          if (config_space_select_bit)
            {next_flash_data_high, next_flash_data_low} = `BLANK_WORD;
          else
            {next_flash_data_high, next_flash_data_low} = fp.rd_data;
          next_read_start = 1'b0;
          next_seq = SEQ_IDLE;
        end
      default:
        next_seq = SEQ_IDLE;
    endcase
  end

  // -------------------------------------------------------------
  // Read answer
  // -------------------------------------------------------------
  // Reads answer one cycle after the request from a register; the
  // unlock register and unmapped words read as zero.
  always_comb
  begin
    next_read_ack = avs_read && !read_ack && !stall_core;
    next_readdata = avs_readdata;
    if (next_read_ack)
    begin
      next_readdata = 32'h0000_0000;
      case (reg_index(avs_address))
        `IDX_CONTROL:
        begin
          next_readdata[`BIT_READ_START] = read_start;
          next_readdata[`BIT_WRITE_START] = write_start;
          next_readdata[`BIT_WRITE_ENABLE] = write_enable_bit;
          next_readdata[`BIT_ROW_ERASE] = row_erase_bit;
          next_readdata[`BIT_LATCH_LOAD_ONLY] = latch_load_only_bit;
          next_readdata[`BIT_CONFIG_SPACE] = config_space_select_bit;
        end
        `IDX_ADDR_LOW:
          next_readdata[7:0] = flash_addr_low;
        `IDX_ADDR_HIGH:
          next_readdata[6:0] = flash_addr_high;
        `IDX_DATA_LOW:
          next_readdata[7:0] = flash_data_low;
        `IDX_DATA_HIGH:
          next_readdata[5:0] = flash_data_high;
        default:
          next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  // Unlock tracking is idle after reset, so no write starts early.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      read_start <= 1'b0;
      write_start <= 1'b0;
      write_enable_bit <= 1'b0;
      row_erase_bit <= 1'b0;
      latch_load_only_bit <= 1'b0;
      config_space_select_bit <= 1'b0;
      flash_addr_low <= 8'h00;
      flash_addr_high <= 7'h00;
      flash_data_low <= 8'h00;
      flash_data_high <= 6'h00;
      op_erase <= 1'b0;
      op_load <= 1'b0;
      timer <= 32'h0000_0000;
      latch <= {16{`BLANK_WORD}};
      seq <= SEQ_IDLE;
      ulk <= ULK_IDLE;
      read_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      read_start <= next_read_start;
      write_start <= next_write_start;
      write_enable_bit <= next_write_enable_bit;
      row_erase_bit <= next_row_erase_bit;
      latch_load_only_bit <= next_latch_load_only_bit;
      config_space_select_bit <= next_config_space_select_bit;
      flash_addr_low <= next_flash_addr_low;
      flash_addr_high <= next_flash_addr_high;
      flash_data_low <= next_flash_data_low;
      flash_data_high <= next_flash_data_high;
      op_erase <= next_op_erase;
      op_load <= next_op_load;
      timer <= next_timer;
      latch <= next_latch;
      seq <= next_seq;
      ulk <= next_ulk;
      read_ack <= next_read_ack;
      avs_readdata <= next_readdata;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  // Stall length counter, read only by the checks below.
  logic [31:0] stall_len;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stall_len <= 32'h0000_0000;
    else
      stall_len <= stall_core ? stall_len + 32'd1 : 32'h0000_0000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_start_forces_nop: assert property (
    $rose(write_start) |-> force_nop)
    else $error("start bit set without forced no-op");
  a_two_nop_slots: assert property (
    (seq == SEQ_NOP2 && instr_slot) |=> !force_nop)
    else $error("forced no-ops exceed two slots");
  a_stall_length: assert property (
    $fell(stall_core) |-> stall_len == OP_CYCLES)
    else $error("stall length differs from operation time");
  a_load_no_stall: assert property (
    (seq == SEQ_NOP2 && instr_slot && op_load)
    |=> !stall_core && !write_start)
    else $error("latch load stalled the core");
  a_unlock_guard: assert property (
    $rose(write_start) |-> $past(ulk) == ULK_ARMED
      && write_enable_bit)
    else $error("write started without unlock or enable");
  a_bad_unlock: assert property (
    (wr_acc && reg_index(avs_address) == `IDX_UNLOCK
      && avs_writedata[7:0] != `UNLOCK_FIRST
      && avs_writedata[7:0] != `UNLOCK_SECOND) |=> ulk == ULK_IDLE)
    else $error("bad unlock value left tracking armed");
  a_read_word: assert property (
    (seq == SEQ_RD2 && instr_slot && !config_space_select_bit)
    |=> data_word == $past(fp.rd_data) && !read_start)
    else $error("fetched word not placed in data pair");
  a_latch_blank: assert property (
    ($fell(write_start) && $past(seq) == SEQ_STALL)
    |-> latch[0] == `BLANK_WORD && latch[15] == `BLANK_WORD)
    else $error("latches not blank after write or erase");
  a_resume_free: assert property (
    $fell(stall_core) |-> !force_nop && seq == SEQ_IDLE)
    else $error("core not released after stall");

endmodule : flash_self_program_unlock_erase

// file: hdl/flash_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the
// flash self-programming sequencer. Guarded, so any number of includers may pull it in.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// Register word indices; the byte address is four times the index.
`define IDX_CONTROL 3'h0
`define IDX_UNLOCK 3'h1
`define IDX_ADDR_LOW 3'h2
`define IDX_ADDR_HIGH 3'h3
`define IDX_DATA_LOW 3'h4
`define IDX_DATA_HIGH 3'h5

// Bit positions inside the control register.
`define BIT_READ_START 0
`define BIT_WRITE_START 1
`define BIT_WRITE_ENABLE 2
`define BIT_ROW_ERASE 4
`define BIT_LATCH_LOAD_ONLY 5
`define BIT_CONFIG_SPACE 6

// Unlock pattern values and the blank flash word.
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'hAA
`define BLANK_WORD 14'h3FFF

// Erase or program time and its count of 8 ns clock cycles.
`define FLASH_OP_TIME_NS 2000000
`define CLK_PERIOD_NS 8
`define FLASH_OP_CYCLES (`FLASH_OP_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: hdl/flash_seq_pkg.sv
// Types shared by the flash sequencer, its port interface and its array.
// Assumes nothing of its surroundings.
package flash_seq_pkg;

  // One flash word and one row of sixteen words.
  typedef logic [13:0] word_t;
  typedef logic [15:0][13:0] row_t;

  // Command handed to the flash array for one cycle.
  typedef enum logic [1:0]
  {
    CMD_NONE = 2'h0,
    CMD_READ = 2'h1,
    CMD_ERASE = 2'h2,
    CMD_PROGRAM = 2'h3
  } flash_cmd_t;

  // Sequencer states, one-hot.
  typedef enum logic [5:0]
  {
    SEQ_IDLE = 6'h01,
    SEQ_NOP1 = 6'h02,
    SEQ_NOP2 = 6'h04,
    SEQ_STALL = 6'h08,
    SEQ_RD1 = 6'h10,
    SEQ_RD2 = 6'h20
  } seq_state_t;

  // Unlock tracking states, one-hot.
  typedef enum logic [2:0]
  {
    ULK_IDLE = 3'h1,
    ULK_GOT_FIRST = 3'h2,
    ULK_ARMED = 3'h4
  } unlock_state_t;

endpackage : flash_seq_pkg

// file: hdl/flash_port_if.sv
// Port between the sequencer and the flash array it commands.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface flash_port_if;
  import flash_seq_pkg::*;

  flash_cmd_t cmd;   // One-cycle command.
  logic [14:0] addr; // Word address; the row is the upper eleven bits.
  row_t row_data;    // Latch contents for a program command.
  word_t rd_data;    // Word fetched by the last read command.

  modport ctrl (output cmd, output addr, output row_data, input rd_data);
  modport mem (input cmd, input addr, input row_data, output rd_data);
endinterface : flash_port_if

// file: hdl/flash_mem.sv
// Program flash array: whole-row erase, row program and word read.
// Assumes commands come from the sequencer on the same clock.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module flash_mem
  import flash_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  flash_port_if.mem port
);

  // Cell storage; it has no reset, so software erases a row before use.
  word_t cells [0:32767];

  // -------------------------------------------------------------
  // Row operations
  // -------------------------------------------------------------
  // All sixteen words of the addressed row are handled in one process,
  // so the array keeps a single driver.
  // Programming can only clear bits, as real flash cells do.
  always_ff @(posedge clk)
  begin
    for (int w = 0; w < 16; w++)
    begin
      if (port.cmd == CMD_ERASE)
        cells[{port.addr[14:4], 4'(w)}] <= `BLANK_WORD;
      else if (port.cmd == CMD_PROGRAM)
        cells[{port.addr[14:4], 4'(w)}] <=
          cells[{port.addr[14:4], 4'(w)}] & port.row_data[w];
    end
  end

  // -------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------
  // The fetched word is registered and held until the next read.
  word_t next_rd_data;

  always_comb
  begin
    next_rd_data = port.rd_data;
    if (port.cmd == CMD_READ)
      next_rd_data = cells[port.addr];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port.rd_data <= 14'h0000;
    else
      port.rd_data <= next_rd_data;
  end

endmodule : flash_mem

// file: test/core_model.sv
// Core model: issues instruction slots and obeys the flash handshake.
// Assumes it shares clk and rst with the sequencer.
`timescale 1ns/1ps

module core_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] gap,
  input wire logic force_nop,
  input wire logic stall_core,
  output logic instr_slot,
  output logic [7:0] nop_cnt,
  output logic [7:0] exec_cnt,
  output logic [15:0] stall_cnt
);
  logic [3:0] phase; // Cycles since the last slot.

  // One slot every gap cycles; gap of two at least, so no slot lands in
  // the cycle a start bit rises. Counts clear while the core is idle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= 4'h0;
      instr_slot <= 1'b0;
      nop_cnt <= 8'h00;
      exec_cnt <= 8'h00;
      stall_cnt <= 16'h0000;
    end
    else if (!run)
    begin
      // An idle core issues nothing and forgets its counts.
      phase <= 4'h0;
      instr_slot <= 1'b0;
      nop_cnt <= 8'h00;
      exec_cnt <= 8'h00;
      stall_cnt <= 16'h0000;
    end
    else
    begin
      if (stall_core)
        stall_cnt <= stall_cnt + 16'h0001;
      else if (instr_slot && force_nop)
        nop_cnt <= nop_cnt + 8'h01;
      else if (instr_slot)
        exec_cnt <= exec_cnt + 8'h01;
      if (stall_core)
      begin
        // A halted core issues nothing.
        phase <= 4'h0;
        instr_slot <= 1'b0;
      end
      else if (phase == gap - 4'h1)
      begin
        phase <= 4'h0;
        instr_slot <= 1'b1;
      end
      else
      begin
        phase <= phase + 4'h1;
        instr_slot <= 1'b0;
      end
    end
  end
endmodule : core_model

// file: test/flash_self_program_unlock_erase_test.sv
// Testbench of the flash sequencer: Avalon-MM register access, unlock
// guard, latch load, erase, program and read through a core model.
// Assumes the design files and the core model are compiled first.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

`define CHECK_EQ(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end

module flash_self_program_unlock_erase_test;
  localparam int unsigned OP = 20; // Short flash time keeps runs brief.
  localparam logic [31:0] RS = 32'h1 << `BIT_READ_START;
  localparam logic [31:0] WS = 32'h1 << `BIT_WRITE_START;
  localparam logic [31:0] WE = 32'h1 << `BIT_WRITE_ENABLE;
  localparam logic [31:0] FR = 32'h1 << `BIT_ROW_ERASE;
  localparam logic [31:0] LW = 32'h1 << `BIT_LATCH_LOAD_ONLY;
  localparam logic [31:0] CF = 32'h1 << `BIT_CONFIG_SPACE;

  logic clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic instr_slot;
  logic force_nop;
  logic stall_core;
  logic run; // Core executes while high.
  logic [3:0] gap; // Cycles between slots: 2 is prompt, 5 is slow.
  logic [7:0] nop_cnt;
  logic [7:0] exec_cnt;
  logic [15:0] stall_cnt;
  int n_mismatch;
  int n_tests;

  flash_self_program_unlock_erase #(.OP_CYCLES(OP))
    u_flash_self_program_unlock_erase
  (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instr_slot(instr_slot),
    .force_nop(force_nop), .stall_core(stall_core)
  );

  core_model u_core_model
  (
    .clk(clk), .rst(rst), .run(run), .gap(gap), .force_nop(force_nop),
    .stall_core(stall_core), .instr_slot(instr_slot),
    .nop_cnt(nop_cnt), .exec_cnt(exec_cnt), .stall_cnt(stall_cnt)
  );

  // -------------------------------------------------------------------
  // Bus and core tasks
  // -------------------------------------------------------------------

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr_n_rd, input logic [2:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdv);
    int i;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr_n_rd;
    avs_read <= !wr_n_rd;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // A slave that never answers ends the run.
    if (i == 100)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, d, unused);
  endtask : wr

  task automatic check_reg(input string what, input logic [2:0] idx,
                           input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    `CHECK_EQ(what, exp, v);
  endtask : check_reg

  // Loads the address pair and the data pair.
  task automatic load(input logic [14:0] a, input logic [13:0] d);
    wr(`IDX_ADDR_LOW, {24'h0, a[7:0]});
    wr(`IDX_ADDR_HIGH, {25'h0, a[14:8]});
    wr(`IDX_DATA_LOW, {24'h0, d[7:0]});
    wr(`IDX_DATA_HIGH, {26'h0, d[13:8]});
  endtask : load

  // Unlock pattern run back to back, as with interrupts masked.
  task automatic unlock_start(input logic [31:0] ctrl);
    wr(`IDX_UNLOCK, 32'h55);
    wr(`IDX_UNLOCK, 32'hAA);
    wr(`IDX_CONTROL, ctrl);
  endtask : unlock_start

  // Runs the core until two slots have executed, then checks how many
  // slots were forced and how long the core was halted.
  task automatic run_core(input logic [7:0] nops, input logic [15:0] hold);
    int i;
    run <= 1'b1;
    for (i = 0; i < 400 && exec_cnt !== 8'h02; i++)
      @(posedge clk);
    if (i == 400)
    begin
      n_mismatch++;
      complete_run();
    end
    `CHECK_EQ("forced slots", nops, nop_cnt);
    `CHECK_EQ("stall cycles", hold, stall_cnt);
    run <= 1'b0;
  endtask : run_core

  // Reads one flash word; ordinary program space is selected.
  task automatic read_word(input logic [14:0] a, input logic [13:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    load(a, 14'h0000);
    wr(`IDX_CONTROL, RS);
    run_core(8'h01, 16'h0000);
    bus(1'b0, `IDX_DATA_LOW, 32'h0, lo);
    bus(1'b0, `IDX_DATA_HIGH, 32'h0, hi);
    `CHECK_EQ("flash word", exp, {hi[5:0], lo[7:0]});
  endtask : read_word

  // -------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // -------------------------------------------------------------------

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Catches any hang that the bounded loops miss.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    run = 1'b0;
    gap = 4'h2;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped place and the write-only unlock register.
    check_reg("control", `IDX_CONTROL, 32'h0);
    check_reg("unmapped", 3'h6, 32'h0);
    wr(`IDX_UNLOCK, 32'h55);
    check_reg("unlock", `IDX_UNLOCK, 32'h0);
    // Half a pattern, then start: nothing may begin.
    wr(`IDX_CONTROL, WE | WS);
    check_reg("control", `IDX_CONTROL, WE);
    // Full pattern but writes not enabled.
    unlock_start(FR | WS);
    check_reg("control", `IDX_CONTROL, FR);
    // A wrong value in mid-pattern sends tracking back to idle.
    wr(`IDX_UNLOCK, 32'h55);
    wr(`IDX_UNLOCK, 32'h33);
    wr(`IDX_UNLOCK, 32'hAA);
    wr(`IDX_CONTROL, WE | WS);
    check_reg("control", `IDX_CONTROL, WE);
    // Another write between pattern and start disarms it.
    wr(`IDX_UNLOCK, 32'h55);
    wr(`IDX_UNLOCK, 32'hAA);
    wr(`IDX_ADDR_LOW, 32'h0);
    wr(`IDX_CONTROL, WE | WS);
    check_reg("control", `IDX_CONTROL, WE);
    `CHECK_EQ("force_nop", 1'b0, force_nop);
    // Latch load only: two forced slots, no stall.
    load(15'h0125, 14'h0123);
    unlock_start(WE | LW | WS);
    run_core(8'h02, 16'h0000);
    check_reg("control", `IDX_CONTROL, WE | LW);
    // Row erase by an address inside the row; software cannot clear WS.
    load(15'h0123, 14'h0000);
    unlock_start(WE | FR | WS);
    wr(`IDX_CONTROL, WE | FR);
    check_reg("control", `IDX_CONTROL, WE | FR | WS);
    run_core(8'h02, OP[15:0]);
    check_reg("control", `IDX_CONTROL, WE | FR);
    // Program one word with a slow core.
    gap <= 4'h5;
    load(15'h0127, 14'h2A5A);
    unlock_start(WE | WS);
    run_core(8'h02, OP[15:0]);
    gap <= 4'h2;
    read_word(15'h0127, 14'h2A5A);
    read_word(15'h0125, 14'h3FFF);
    read_word(15'h012F, 14'h3FFF);
    // A loaded latch reaches flash only with the next program.
    load(15'h0129, 14'h0000);
    unlock_start(WE | LW | WS);
    run_core(8'h02, 16'h0000);
    read_word(15'h0129, 14'h3FFF);
    load(15'h012A, 14'h1111);
    unlock_start(WE | WS);
    run_core(8'h02, OP[15:0]);
    read_word(15'h0129, 14'h0000);
    read_word(15'h012A, 14'h1111);
    // Config select steers a read away from program flash.
    load(15'h0127, 14'h0000);
    wr(`IDX_CONTROL, CF | RS);
    run_core(8'h01, 16'h0000);
    check_reg("config low", `IDX_DATA_LOW, 32'hFF);
    check_reg("config high", `IDX_DATA_HIGH, 32'h3F);
    complete_run();
  end
endmodule : flash_self_program_unlock_erase_test
